// >>> inc/svd_pkg.sv
// Purpose: Shared constants and types for the supply voltage detector.
// Assumes: 20 MHz peripheral bus clock, one clock domain.
// Notes:   Byte addresses on a 5-bit register port, 32-bit data.
package svd_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] CTRL_OFS = 5'h00; // voltage_detect_control
  localparam logic [4:0] CLR_OFS  = 5'h04; // Clear alias
  localparam logic [4:0] SET_OFS  = 5'h08; // Set alias
  localparam logic [4:0] INV_OFS  = 5'h0C; // Invert alias
  localparam logic [4:0] STAT_OFS = 5'h10; // Interrupt status
  localparam logic [4:0] MASK_OFS = 5'h14; // Interrupt mask

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned ENABLE_BIT    = 15;
  localparam int unsigned STOP_IDLE_BIT = 13;
  localparam int unsigned DIR_BIT       = 11;
  localparam int unsigned BG_BIT        = 10;
  localparam int unsigned IREF_BIT      = 9;
  localparam int unsigned EVT_BIT       = 8;
  localparam int unsigned LEVEL_LSB     = 0;
  localparam int unsigned LEVEL_W       = 4;
  localparam logic [31:0] CTRL_WR_MASK  = 32'h0000A80F;
  localparam logic [LEVEL_W-1:0] LEVEL_EXT       = 4'hF;
  localparam logic [LEVEL_W-1:0] LEVEL_MIN_VALID = 4'h5;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET     = 4'h0;

  // ---------------------------------------------------------------
  // Interrupt status and mask fields
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_DETECT_BIT = 0;
  localparam int unsigned IRQ_REFOK_BIT  = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic comp_above;  // Monitored voltage at or above trip point
    logic bandgap_ok;  // Band gap stable
    logic ref_ok;      // Internal reference stable
  } svd_analog_s;

  typedef struct packed {
    logic               enable;
    logic               stop_in_idle;
    logic               crossing_direction;
    logic [LEVEL_W-1:0] trip_level_code;
  } svd_ctrl_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } svd_bus_req_s;

  typedef struct packed {
    svd_ctrl_s         ctrl;
    logic              run;
    logic              evt_active;
    logic              ref_ok_d;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [31:0]       rdata;
  } svd_state_s;

  localparam svd_ctrl_s CTRL_RESET = '{enable: 1'b0, stop_in_idle: 1'b0,
    crossing_direction: 1'b0, trip_level_code: LEVEL_RESET};

endpackage

// >>> rtl/svd_sync.sv
// Purpose: Two-flop synchroniser for the analog status levels.
// Assumes: Inputs are slow levels from the analog detector.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module svd_sync (
  input  wire logic                 sys_clk_in,
  input  wire logic                 nrst_in,
  input  wire svd_pkg::svd_analog_s raw_in,
  output svd_pkg::svd_analog_s      sync_out
);

  typedef struct packed {
    svd_pkg::svd_analog_s meta;
    svd_pkg::svd_analog_s stable;
  } svd_sync_s;

  svd_sync_s state_reg;
  svd_sync_s state_next;

  // Shift the raw level through both stages
  always_comb begin
    state_next.meta   = raw_in;
    state_next.stable = state_reg.meta;
  end

  // Flags read as unstable until the analog side proves otherwise
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule // svd_sync

// >>> rtl/svd_ctrl.sv
// Purpose: Control and status logic of the supply voltage detector.
// Assumes: Analog comparator, references and trip ladder sit outside;
//          register port is a single-cycle strobe port, no wait states.
// Notes:   Control register with clear, set and invert aliases, plus
//          an interrupt status and mask pair driving one level output.
//
// Operation
// - Raise the detect interrupt flag when voltage crosses trip point.
// - Enable bit 15 powers detection; no events while disabled.
// - Bit 13 set stops the detector while the device is idle.
// - Bit 11 picks rising-or-equal or strictly falling (below) crossing.
// - Read-only bit 10 shows band gap stability, resets to zero.
// - Bit 9 shows reference stability; no flag while it is zero.
// - Read-only bit 8 is high while a detection event is active.
// - Bits 3 to 0 hold the trip level code, read/write, reset zero.
// - Code 1111 compares the external sense input with band gap.
// - Codes 1110 to 0101 select internal trip levels, low to high.
// - Clear, set and invert aliases sit at plus 4, 8 and C.
// - Unimplemented bits read as zero and ignore writes.
`timescale 1ns/1ps
module svd_ctrl (
  input  wire logic                  sys_clk_in,
  input  wire logic                  nrst_in,
  input  wire svd_pkg::svd_bus_req_s bus_req_in,
  output logic [31:0]                rdata_out,
  input  wire logic                  idle_in,
  input  wire svd_pkg::svd_analog_s  analog_in,
  output logic                       detector_enable_out,
  output logic [3:0]                 trip_level_code_out,
  output logic                       ext_sense_select_out,
  output logic                       crossing_direction_out,
  output logic                       detect_event_active_out,
  output logic                       irq_out
);

  // -----------------------------------------------------------------
  // Helper functions
  // -----------------------------------------------------------------

  // Field packing lives in functions so the aliases, the direct write
  // and the readback all agree on one bit layout.
  // Unpack the writable bits of a control word
  function automatic svd_pkg::svd_ctrl_s ctrl_from_word(
    input logic [31:0] word
  );
    svd_pkg::svd_ctrl_s c;
    c.enable             = word[svd_pkg::ENABLE_BIT];
    c.stop_in_idle       = word[svd_pkg::STOP_IDLE_BIT];
    c.crossing_direction = word[svd_pkg::DIR_BIT];
    c.trip_level_code    =
      word[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W];
    return c;
  endfunction

  // Pack the writable bits back into a word, all others zero
  function automatic logic [31:0] ctrl_to_word(
    input svd_pkg::svd_ctrl_s c
  );
    logic [31:0] w;
    w = '0;
    w[svd_pkg::ENABLE_BIT]    = c.enable;
    w[svd_pkg::STOP_IDLE_BIT] = c.stop_in_idle;
    w[svd_pkg::DIR_BIT]       = c.crossing_direction;
    w[svd_pkg::LEVEL_LSB +: svd_pkg::LEVEL_W] = c.trip_level_code;
    return w;
  endfunction

  // Widen the interrupt field to a bus word
  function automatic logic [31:0] irq_to_word(
    input logic [svd_pkg::IRQ_W-1:0] bits
  );
    logic [31:0] w;
    w = '0;
    w[svd_pkg::IRQ_W-1:0] = bits;
    return w;
  endfunction

  // True when a write strobe hits the given register offset
  function automatic logic wr_hit(
    input svd_pkg::svd_bus_req_s      req,
    input logic [svd_pkg::ADDR_W-1:0] ofs
  );
    return req.wr && (req.addr == ofs);
  endfunction

  // True when a read strobe hits the given register offset
  function automatic logic rd_hit(
    input svd_pkg::svd_bus_req_s      req,
    input logic [svd_pkg::ADDR_W-1:0] ofs
  );
    return req.rd && (req.addr == ofs);
  endfunction

  // Control word as software sees it, hardware flags merged in;
  // the flags are live, so a read shows their synchronised levels, not the raw analog inputs
  function automatic logic [31:0] ctrl_readback(
    input logic [31:0]          word,
    input svd_pkg::svd_analog_s flags,
    input logic                 evt
  );
    logic [31:0] w;
    w = word;
    w[svd_pkg::BG_BIT]   = flags.bandgap_ok;
    w[svd_pkg::IREF_BIT] = flags.ref_ok;
    w[svd_pkg::EVT_BIT]  = evt;
    return w;
  endfunction

  // -----------------------------------------------------------------
  // Synchronised analog status
  // -----------------------------------------------------------------
  svd_pkg::svd_analog_s analog_sync;

  // Each flag is synchronised on its own; flags that change together
  // may be seen one cycle apart from each other.
  // Analog levels arrive unclocked, so two flops before any logic
  svd_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .raw_in     (analog_in),
    .sync_out   (analog_sync)
  );

  // -----------------------------------------------------------------
  // State and decode
  // -----------------------------------------------------------------
  svd_pkg::svd_state_s state_reg;
  svd_pkg::svd_state_s state_next;

  logic        wr_ctrl;
  logic        wr_clr;
  logic        wr_set;
  logic        wr_inv;
  logic        wr_mask;
  logic        rd_stat;
  logic [31:0] wr_bits;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_upd;
  logic        run_now;
  logic        level_valid;
  logic        crossed;
  logic        evt_now;
  logic        evt_rise;
  logic        ref_rise;
  logic [svd_pkg::IRQ_W-1:0] irq_set;

  // Address decode of the strobes; the port carries one address, so
  // at most one of these can be high in any cycle
  always_comb begin
    wr_ctrl = wr_hit(bus_req_in, svd_pkg::CTRL_OFS);
    wr_clr  = wr_hit(bus_req_in, svd_pkg::CLR_OFS);
    wr_set  = wr_hit(bus_req_in, svd_pkg::SET_OFS);
    wr_inv  = wr_hit(bus_req_in, svd_pkg::INV_OFS);
    wr_mask = wr_hit(bus_req_in, svd_pkg::MASK_OFS);
    rd_stat = rd_hit(bus_req_in, svd_pkg::STAT_OFS);
    // Read-only and unimplemented bits never reach storage
    wr_bits = bus_req_in.wdata & svd_pkg::CTRL_WR_MASK;
  end

  // Aliases act only on bits written as one, so software can change
  // one field without a read-modify-write that might race an update.
  // Control word update, direct write or one of the aliases
  always_comb begin
    ctrl_word = ctrl_to_word(state_reg.ctrl);
    ctrl_upd  = ctrl_word;
    if (wr_ctrl) begin
      ctrl_upd = wr_bits;
    end else if (wr_clr) begin
      ctrl_upd = ctrl_word & ~wr_bits;
    end else if (wr_set) begin
      ctrl_upd = ctrl_word | wr_bits;
    end else if (wr_inv) begin
      ctrl_upd = ctrl_word ^ wr_bits;
    end
  end

  // -----------------------------------------------------------------
  // Detection qualification
  // -----------------------------------------------------------------

  // Run is run_now (enable and not idle-stopped) one cycle old and also drives the analog side, so
  // its comparator output is believed from the first powered cycle.
  // The detector runs only when enabled and not halted by idle
  always_comb begin
    run_now = state_reg.ctrl.enable
      && !(idle_in && state_reg.ctrl.stop_in_idle);
    // Reserved codes select no trip level, so they never detect;
    // code 1111 and 1110..0101 are all at or above the minimum
    level_valid = (state_reg.ctrl.trip_level_code >=
                   svd_pkg::LEVEL_MIN_VALID);
    // Equal counts as crossed only in the rising direction
    crossed = state_reg.ctrl.crossing_direction
            ? analog_sync.comp_above
            : !analog_sync.comp_above;
    // An unstable reference suppresses the event entirely
    evt_now = state_reg.run && run_now && level_valid && crossed
            && analog_sync.ref_ok;
  end

  // Without the edge, a level that stays true would set the sticky
  // flag again right after every status read.
  // Edge detection turns levels into one-shot interrupt sources
  always_comb begin
    evt_rise = evt_now && !state_reg.evt_active;
    ref_rise = analog_sync.ref_ok && !state_reg.ref_ok_d;
    irq_set  = '0;
    irq_set[svd_pkg::IRQ_DETECT_BIT] = evt_rise;
    irq_set[svd_pkg::IRQ_REFOK_BIT]  = ref_rise;
  end

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------

  // One process builds the whole next state, so every field has one
  // driver and one place that states its update rule.
  always_comb begin
    state_next            = state_reg;
    state_next.ctrl       = ctrl_from_word(ctrl_upd);
    state_next.run        = run_now;
    state_next.evt_active = evt_now;
    state_next.ref_ok_d   = analog_sync.ref_ok;

    // Set wins over clear, so software never loses an event that
    // arrives in the very cycle of its status read.
    // Read clears the sticky bits, a same-cycle event still lands
    if (rd_stat) begin
      state_next.irq_status = irq_set;
    end else begin
      state_next.irq_status = state_reg.irq_status | irq_set;
    end

    // Only the implemented mask bits are kept, the rest read as zero
    if (wr_mask) begin
      state_next.irq_mask = bus_req_in.wdata[svd_pkg::IRQ_W-1:0];
    end

    // Read data stands for exactly one cycle, zero otherwise
    state_next.rdata = '0;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        svd_pkg::CTRL_OFS,
        svd_pkg::CLR_OFS,
        svd_pkg::SET_OFS,
        svd_pkg::INV_OFS: begin
          state_next.rdata = ctrl_readback(ctrl_word, analog_sync,
            state_reg.evt_active);
        end
        svd_pkg::STAT_OFS: begin
          state_next.rdata = irq_to_word(state_reg.irq_status);
        end
        svd_pkg::MASK_OFS: begin
          state_next.rdata = irq_to_word(state_reg.irq_mask);
        end
        default: begin
          state_next.rdata = '0; // Unmapped reads return zero
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------

  // Limitation: after any reset the detector stays off until software
  // enables it again; no setting survives a reset.
  // Everything clears at reset, so the detector starts powered down
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg.ctrl       <= svd_pkg::CTRL_RESET;
      state_reg.run        <= 1'b0;
      state_reg.evt_active <= 1'b0;
      state_reg.ref_ok_d   <= 1'b0;
      state_reg.irq_status <= svd_pkg::IRQ_RESET;
      state_reg.irq_mask   <= svd_pkg::IRQ_RESET;
      state_reg.rdata      <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------

  // External select follows the enable bit, so the sense pin is not
  // loaded while the detector is disabled; stop-in-idle leaves it on.
  // Analog side controls come from flops; ext select ANDs two of them
  assign detector_enable_out     = state_reg.run;
  assign trip_level_code_out     = state_reg.ctrl.trip_level_code;
  assign ext_sense_select_out    = state_reg.ctrl.enable
    && (state_reg.ctrl.trip_level_code == svd_pkg::LEVEL_EXT);
  assign crossing_direction_out  = state_reg.ctrl.crossing_direction;
  assign detect_event_active_out = state_reg.evt_active;
  assign rdata_out               = state_reg.rdata;

  // Masking hides a flag without clearing it, so unmasking later shows
  // an event that happened while it was hidden.
  // Level interrupt, high while any unmasked sticky bit is set
  assign irq_out = |(state_reg.irq_status & state_reg.irq_mask);

endmodule // svd_ctrl

// >>> sim/svd_ctrl_checker.sv
// Purpose: Concurrent checks on the detector control block ports.
// Assumes: One clock domain, async active-low reset.
// Notes:   Attached to every svd_ctrl instance by bind.
`timescale 1ns/1ps
module svd_ctrl_checker (
  input wire logic                  sys_clk_in,
  input wire logic                  nrst_in,
  input wire svd_pkg::svd_bus_req_s bus_req_in,
  input wire logic [31:0]           rdata_out,
  input wire svd_pkg::svd_analog_s  analog_in,
  input wire logic                  detector_enable_out,
  input wire logic [3:0]            trip_level_code_out,
  input wire logic                  ext_sense_select_out,
  input wire logic                  crossing_direction_out,
  input wire logic                  detect_event_active_out
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // One bus write to a given place
  sequence s_wr(logic [4:0] a);
    bus_req_in.wr && bus_req_in.addr == a;
  endsequence
  // One bus read from a given place
  sequence s_rd(logic [4:0] a);
    bus_req_in.rd && bus_req_in.addr == a;
  endsequence
  // Input staying on the non-tripping side long enough to pass sync
  sequence s_quiet;
    (analog_in.comp_above != crossing_direction_out)[*4];
  endsequence
  property p_rd_only;
    rdata_out != 32'h0 |-> $past(bus_req_in.rd);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("data without read");
  property p_unimpl;
    bus_req_in.rd |=> (rdata_out & 32'hFFFF50F0) == 32'h0;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bit set");
  property p_ctrl_rd;
    (s_rd(svd_pkg::INV_OFS) or s_rd(svd_pkg::CTRL_OFS))
      |=> rdata_out[3:0] == $past(trip_level_code_out);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("level readback");
  property p_ctrl_wr;
    s_wr(svd_pkg::CTRL_OFS) |=> trip_level_code_out ==
      $past(bus_req_in.wdata[3:0]) &&
      crossing_direction_out == $past(bus_req_in.wdata[11]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write");
  property p_set;
    s_wr(svd_pkg::SET_OFS) |=> trip_level_code_out ==
      ($past(trip_level_code_out) | $past(bus_req_in.wdata[3:0]));
  endproperty
  a_set: assert property (p_set) else $error("set alias");
  property p_clr;
    s_wr(svd_pkg::CLR_OFS) |=> trip_level_code_out ==
      ($past(trip_level_code_out) & ~$past(bus_req_in.wdata[3:0]));
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias");
  property p_inv;
    s_wr(svd_pkg::INV_OFS) |=> trip_level_code_out ==
      ($past(trip_level_code_out) ^ $past(bus_req_in.wdata[3:0]));
  endproperty
  a_inv: assert property (p_inv) else $error("invert alias");
  property p_evt_en;
    detect_event_active_out |-> $past(detector_enable_out);
  endproperty
  a_evt_en: assert property (p_evt_en) else $error("event while off");
  property p_evt_code;
    detect_event_active_out |-> $past(trip_level_code_out) >= 4'h5;
  endproperty
  a_evt_code: assert property (p_evt_code) else $error("reserved code");
  property p_dir;
    s_quiet |-> !detect_event_active_out;
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_ext;
    ext_sense_select_out |-> trip_level_code_out == 4'hF ||
      $past(trip_level_code_out) == 4'hF;
  endproperty
  a_ext: assert property (p_ext) else $error("external select");
endmodule // svd_ctrl_checker

bind svd_ctrl svd_ctrl_checker u_chk (
  .sys_clk_in              (sys_clk_in),
  .nrst_in                 (nrst_in),
  .bus_req_in              (bus_req_in),
  .rdata_out               (rdata_out),
  .analog_in               (analog_in),
  .detector_enable_out     (detector_enable_out),
  .trip_level_code_out     (trip_level_code_out),
  .ext_sense_select_out    (ext_sense_select_out),
  .crossing_direction_out  (crossing_direction_out),
  .detect_event_active_out (detect_event_active_out)
);

// >>> sim/svd_tb.sv
// Purpose: Self-checking bench for the detector control block.
// Assumes: 20 MHz clock; bench drives bus and analog levels itself.
// Notes:   Each trial waits out the two-stage level synchroniser.
`timescale 1ns/1ps
module testbench;
  logic                  sys_clk_in;
  logic                  nrst_in;
  svd_pkg::svd_bus_req_s req;
  svd_pkg::svd_analog_s  ana;
  logic                  idle;
  logic [31:0]           rdata_out;
  logic                  det_en, ext_sel, dir_out, evt, irq_out;
  logic [3:0]            lvl;
  int                    fail_count;
  int                    checked;

  svd_ctrl dut (
    .sys_clk_in (sys_clk_in), .nrst_in (nrst_in), .bus_req_in (req),
    .rdata_out (rdata_out), .idle_in (idle), .analog_in (ana),
    .detector_enable_out (det_en), .trip_level_code_out (lvl),
    .ext_sense_select_out (ext_sel), .crossing_direction_out (dir_out),
    .detect_event_active_out (evt), .irq_out (irq_out)
  );

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  always #25 sys_clk_in = ~sys_clk_in;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
    // Idle edge, so a following call never drives wr in this step
    @(posedge sys_clk_in);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk_in);
    req.rd <= 1'b0;
    // Data launched at the taking edge still stand at the next one
    @(posedge sys_clk_in);
    d = rdata_out;
  endtask

  task automatic rc(input logic [4:0] a, input logic [31:0] e,
                    input string n);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  task automatic finish_test;
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rc(5'h00, 32'h0, "ctrl_reset");
    rc(5'h18, 32'h0, "unmapped");
    wr(5'h00, 32'hFFFFFFFF);
    rc(5'h00, 32'h0000A80F, "ctrl_all");
    chk("ext_sel", 32'h1, ext_sel);
    chk("level", 32'hF, lvl);
    wr(5'h04, 32'h0000800F);
    rc(5'h0C, 32'h00002800, "ctrl_clr");
    wr(5'h08, 32'h00000005);
    rc(5'h08, 32'h00002805, "ctrl_set");
    wr(5'h0C, 32'h0000A80C);
    rc(5'h04, 32'h00008009, "ctrl_inv");
  endtask

  // Status flags follow the reference levels; mask opened only after
  task automatic t_flags;
    wr(5'h00, 32'h0);
    ana.bandgap_ok <= 1'b1;
    ana.ref_ok <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rc(5'h00, 32'h00000600, "stable");
    rc(5'h10, 32'h2, "stat_ref");
    rc(5'h10, 32'h0, "stat_clr");
    wr(5'h14, 32'hFFFFFFFF);
    rc(5'h14, 32'h3, "mask");
    wr(5'h14, 32'h1);
  endtask

  // Arm, clear status, then cross the trip point once
  task automatic trial(input logic [31:0] c, input logic idl,
                       input logic rok, input logic ex);
    logic [31:0] d;
    ana.comp_above <= ~c[11];
    ana.ref_ok <= rok;
    idle <= idl;
    wr(5'h00, c);
    repeat (6) @(posedge sys_clk_in);
    chk("det_en", c[15] & ~(idl & c[13]), det_en);
    chk("dir", c[11], dir_out);
    chk("ext_sel_cfg", c[15] & (c[3:0] == 4'hF), ext_sel);
    rd(5'h10, d);
    ana.comp_above <= c[11];
    repeat (6) @(posedge sys_clk_in);
    chk("event", ex, evt);
    chk("irq", ex, irq_out);
    rd(5'h00, d);
    chk("evt_bit", ex, d[8]);
    rd(5'h10, d);
    chk("stat_evt", ex, d[0]);
    chk("irq_clr", 32'h0, irq_out);
    repeat (3) @(posedge sys_clk_in);
    chk("irq_once", 32'h0, irq_out);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    nrst_in = 1'b0;
    req = '0;
    ana = '0;
    idle = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (12) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    t_regs();
    t_flags();
    trial(32'h0000880E, 1'b0, 1'b1, 1'b1);
    trial(32'h0000080E, 1'b0, 1'b1, 1'b0);
    trial(32'h0000800E, 1'b0, 1'b1, 1'b1);
    trial(32'h0000A80E, 1'b1, 1'b1, 1'b0);
    trial(32'h0000880E, 1'b1, 1'b1, 1'b1);
    trial(32'h0000880E, 1'b0, 1'b0, 1'b0);
    trial(32'h00008805, 1'b0, 1'b1, 1'b1);
    trial(32'h0000880F, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      trial(32'h00008800 | i, 1'b0, 1'b1, 1'b0);
    end
    finish_test();
  end

  // Run needs well under a thousand cycles; hang guard
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    fail_count++;
    finish_test();
  end
endmodule // testbench
